// ==== change_delay.sv ====
// Purpose: passes a level change once it has stood a set time
// Assumes: delay given in 0.1 s steps
// Notes: first step may be short by up to one tick
`timescale 1ns/1ns
module change_delay #(
  parameter int TICK_CYCLES = drive_terms_pkg::DELAY_TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // level and setting
  input wire logic level_in,
  input wire logic [15:0] delay,
  output logic level_ff
);
  logic [31:0] tick_ff;
  logic [15:0] count_ff;
  logic tick;

  assign tick = (tick_ff == 32'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_ff <= 32'h0;
    else if (ce)
      tick_ff <= tick ? 32'h0 : tick_ff + 32'h1;
  end

  // a change that reverts in time is dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_ff <= 1'b0;
      count_ff <= 16'h0;
    end
    else if (ce)
    begin
      if (level_in == level_ff)
        count_ff <= 16'h0;
      else if (delay == 16'h0)
        level_ff <= level_in;
      else if (tick)
      begin
        if (count_ff + 16'h1 >= delay) // RULE_16
        begin
          level_ff <= level_in;
          count_ff <= 16'h0;
        end
        else
          count_ff <= count_ff + 16'h1;
      end
    end
  end
endmodule

// ==== drive_input_terminal_logic.sv ====
// Purpose: run decode, input polarity and delay, up/down ramp,
//   analog and pulse scaling
// Assumes: pins synchronous, high = closed to common
// Notes: analog in 0.01 V or 0.01 mA
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ns

// Behaviour
// RULE_01 - mode 2: input three enables, input one forward, input two reverse
// RULE_02 - mode 2, enabled: each direction press runs that way
// RULE_03 - both three-wire modes stop at once when enable goes inactive
// RULE_04 - operator holds enable during running; state follows last input action
// RULE_05 - mode 3: input three enables, input one starts, input two sets direction
// RULE_06 - mode 3: start press runs; direction reverse while input two active
// RULE_07 - up/down adjusts frequency at programmable rate, default 1.0 Hz/s
// RULE_08 - rate unit 0.001 Hz/s at resolution 2, 0.01 Hz/s at resolution 1
// RULE_09 - analog input maps linearly between two points within 0 to 10 V
// RULE_10 - input above maximum is evaluated at the maximum point
// RULE_11 - below minimum: digit 0 gives minimum setting, digit 1 gives zero
// RULE_12 - current mode counts each 1 mA as 0.5 V
// RULE_13 - each analog input has a filter, 0 to 10 s, default 0.10 s
// RULE_14 - pulse rate on input five maps onto a setting, up to 50 kHz, filtered
// RULE_15 - decimal digits select each analog input's curve, default 321
// RULE_16 - inputs one and two respond after a delay up to 3600 s
// RULE_17 - five polarity digits, default zero, zero means active when closed
// RULE_18 - polarity digit one inverts the input sense
module drive_input_terminal_logic #(
  parameter int RAMP_TICK_CYCLES = drive_terms_pkg::RAMP_TICK_CYCLES,
  parameter int FILTER_TICK_CYCLES = drive_terms_pkg::FILTER_TICK_CYCLES,
  parameter int DELAY_TICK_CYCLES = drive_terms_pkg::DELAY_TICK_CYCLES,
  parameter int PULSE_WINDOW_CYCLES = drive_terms_pkg::PULSE_WINDOW_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // terminals
  input wire logic digital_input_one,
  input wire logic digital_input_two,
  input wire logic digital_input_three,
  input wire logic digital_input_four,
  input wire logic digital_input_five,
  input wire logic frequency_up,
  input wire logic frequency_down,
  input wire logic [15:0] analog_input_one,
  input wire logic [15:0] analog_input_two,
  // results
  output logic forward_command,
  output logic reverse_command,
  output logic signed [15:0] setting_one,
  output logic signed [15:0] setting_two,
  output logic signed [15:0] pulse_setting,
  output logic [31:0] updown_frequency
);
  typedef enum logic [1:0] {run_stop, run_fwd, run_rev} run_state_type;

  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [1:0] mode_ff;
  logic [1:0] res_ff;
  logic [1:0] current_ff;
  logic [15:0] rate_ff;
  logic [16:0] curve_sel_ff;
  logic [16:0] below_ff;
  logic [16:0] polarity_ff;
  logic [15:0] delay_ff [2];
  drive_terms_pkg::curve_param_type curve_ff [drive_terms_pkg::CURVE_SETS];
  logic [31:0] freq_ff;
  logic [31:0] ramp_tick_ff;
  logic [31:0] window_ff;
  logic [15:0] edge_count_ff;
  logic [15:0] pulse_rate_ff;
  logic pulse_prev_ff;
  logic [1:0] press_prev_ff;
  run_state_type run_state_ff;
  run_state_type nxt_run_state;
  drive_terms_pkg::run_cmd_type cmd_ff;

  logic [4:0] raw;
  logic [4:0] active;
  logic [1:0] delayed;
  logic [1:0] press;
  logic wr_en;
  logic setup;
  logic [31:0] rd_value;
  logic rd_known;
  logic [1:0] set_idx;
  logic [2:0] field_idx;
  logic [31:0] step;
  logic [15:0] sample [2];
  drive_terms_pkg::curve_param_type chosen [2];

  // decimal digit of a binary setting
  function automatic logic [3:0] dec_digit(input logic [16:0] value, input int pos);
    logic [16:0] v;
    v = value;
    for (int i = 0; i < 4; i++)
      if (i < pos)
        v = v / 17'd10;
    return 4'(v % 17'd10);
  endfunction

  function automatic logic [15:0] clamp_set(input logic [15:0] value);
    if ($signed(value) > $signed(drive_terms_pkg::SET_LIMIT))
      return drive_terms_pkg::SET_LIMIT;
    if ($signed(value) < -$signed(drive_terms_pkg::SET_LIMIT))
      return 16'(-$signed(drive_terms_pkg::SET_LIMIT));
    return value;
  endfunction

  function automatic logic [15:0] clamp_max(input logic [15:0] value, input logic [15:0] lim);
    return (value > lim) ? lim : value;
  endfunction

  assign raw = {digital_input_five, digital_input_four, digital_input_three,
                digital_input_two, digital_input_one};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_pol
      assign active[gi] = raw[gi] ^ (dec_digit(polarity_ff, gi) != 4'h0); // RULE_17 RULE_18
    end
    for (gi = 0; gi < 2; gi++)
    begin : g_delay
      change_delay #(
        .TICK_CYCLES(DELAY_TICK_CYCLES)
      ) u_delay (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .level_in(active[gi]),
        .delay(delay_ff[gi]),
        .level_ff(delayed[gi])
      ); // RULE_16
    end
  endgenerate

  // apb: answer one cycle into the access phase
  assign setup = psel && !penable && !pready_ff;
  assign wr_en = psel && penable && pready_ff && pwrite;
  assign set_idx = 2'((paddr - drive_terms_pkg::CURVE_BASE_OFFSET) >> 5);
  assign field_idx = paddr[4:2];

  always_comb
  begin
    rd_known = 1'b1;
    rd_value = 32'h0;
    case (paddr)
      drive_terms_pkg::CTRL_OFFSET:
        rd_value = {26'h0, current_ff, res_ff, mode_ff};
      drive_terms_pkg::UPDOWN_RATE_OFFSET: rd_value = {16'h0, rate_ff};
      drive_terms_pkg::CURVE_SELECT_OFFSET: rd_value = {15'h0, curve_sel_ff};
      drive_terms_pkg::BELOW_MIN_OFFSET: rd_value = {15'h0, below_ff};
      drive_terms_pkg::DELAY_ONE_OFFSET: rd_value = {16'h0, delay_ff[0]};
      drive_terms_pkg::DELAY_TWO_OFFSET: rd_value = {16'h0, delay_ff[1]};
      drive_terms_pkg::POLARITY_OFFSET: rd_value = {15'h0, polarity_ff};
      drive_terms_pkg::STATUS_OFFSET:
        rd_value = {21'h0, delayed, active, 1'b0, cmd_ff};
      drive_terms_pkg::UPDOWN_FREQ_OFFSET: rd_value = freq_ff;
      default:
      begin
        rd_known = 1'b0;
        if (paddr >= drive_terms_pkg::CURVE_BASE_OFFSET
            && paddr <= drive_terms_pkg::CURVE_LAST_OFFSET
            && paddr[1:0] == 2'h0 && field_idx < 3'h5)
        begin
          rd_known = 1'b1;
          case (field_idx)
            3'h0: rd_value = {16'h0, curve_ff[set_idx].min_in};
            3'h1: rd_value = {{16{curve_ff[set_idx].min_set[15]}}, curve_ff[set_idx].min_set};
            3'h2: rd_value = {16'h0, curve_ff[set_idx].max_in};
            3'h3: rd_value = {{16{curve_ff[set_idx].max_set[15]}}, curve_ff[set_idx].max_set};
            default: rd_value = {16'h0, curve_ff[set_idx].filter};
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end
    else if (ce)
    begin
      pready_ff <= setup;
      pslverr_ff <= setup && !rd_known;
      if (setup)
        prdata_ff <= (rd_known && !pwrite) ? rd_value : 32'h0;
    end
  end

  // read-only and unmapped writes are dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ff <= drive_terms_pkg::MODE_RESET;
      res_ff <= drive_terms_pkg::RES_RESET;
      current_ff <= 2'h0;
      rate_ff <= drive_terms_pkg::UPDOWN_RATE_RESET;
      curve_sel_ff <= drive_terms_pkg::CURVE_SELECT_RESET;
      below_ff <= drive_terms_pkg::BELOW_MIN_RESET;
      polarity_ff <= drive_terms_pkg::POLARITY_RESET;
      delay_ff[0] <= drive_terms_pkg::DELAY_RESET;
      delay_ff[1] <= drive_terms_pkg::DELAY_RESET;
      for (int i = 0; i < drive_terms_pkg::CURVE_SETS; i++)
        curve_ff[i] <= drive_terms_pkg::ANALOG_CURVE_RESET;
      curve_ff[drive_terms_pkg::PULSE_SET] <= drive_terms_pkg::PULSE_CURVE_RESET;
    end
    else if (ce && wr_en)
    begin
      case (paddr)
        drive_terms_pkg::CTRL_OFFSET:
        begin
          mode_ff <= pwdata[drive_terms_pkg::CTRL_MODE_LSB +: 2];
          res_ff <= pwdata[drive_terms_pkg::CTRL_RES_LSB +: 2];
          current_ff <= {pwdata[drive_terms_pkg::CTRL_CURRENT_TWO_BIT],
                         pwdata[drive_terms_pkg::CTRL_CURRENT_ONE_BIT]};
        end
        drive_terms_pkg::UPDOWN_RATE_OFFSET: rate_ff <= pwdata[15:0];
        drive_terms_pkg::CURVE_SELECT_OFFSET: curve_sel_ff <= pwdata[16:0];
        drive_terms_pkg::BELOW_MIN_OFFSET: below_ff <= pwdata[16:0];
        drive_terms_pkg::POLARITY_OFFSET: polarity_ff <= pwdata[16:0];
        drive_terms_pkg::DELAY_ONE_OFFSET:
          delay_ff[0] <= clamp_max(pwdata[15:0], drive_terms_pkg::DELAY_LIMIT);
        drive_terms_pkg::DELAY_TWO_OFFSET:
          delay_ff[1] <= clamp_max(pwdata[15:0], drive_terms_pkg::DELAY_LIMIT);
        default:
        begin
          if (rd_known && paddr >= drive_terms_pkg::CURVE_BASE_OFFSET)
          begin
            case (field_idx)
              3'h0: curve_ff[set_idx].min_in <= pwdata[15:0];
              3'h1: curve_ff[set_idx].min_set <= clamp_set(pwdata[15:0]);
              3'h2: curve_ff[set_idx].max_in <= pwdata[15:0];
              3'h3: curve_ff[set_idx].max_set <= clamp_set(pwdata[15:0]);
              default: curve_ff[set_idx].filter <=
                clamp_max(pwdata[15:0], drive_terms_pkg::FILTER_LIMIT);
            endcase
          end
        end
      endcase
    end
  end

  // three-wire decode on delayed inputs one and two, undelayed enable
  assign press = delayed & ~press_prev_ff;

  always_comb
  begin
    nxt_run_state = run_state_ff;
    case (mode_ff)
      drive_terms_pkg::MODE_THREE_ONE:
      begin
        if (!active[2]) // RULE_01 RULE_03
          nxt_run_state = run_stop;
        else if (press[0]) // RULE_02
          nxt_run_state = run_fwd;
        else if (press[1])
          nxt_run_state = run_rev;
      end
      drive_terms_pkg::MODE_THREE_TWO:
      begin
        if (!active[2]) // RULE_05 RULE_03
          nxt_run_state = run_stop;
        else if (press[0] || run_state_ff != run_stop) // RULE_06
          nxt_run_state = delayed[1] ? run_rev : run_fwd;
      end
      default: nxt_run_state = run_stop;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_state_ff <= run_stop;
      press_prev_ff <= 2'h0;
      cmd_ff <= '0;
    end
    else if (ce)
    begin
      run_state_ff <= nxt_run_state;
      press_prev_ff <= delayed;
      cmd_ff.run <= nxt_run_state != run_stop;
      cmd_ff.forward <= nxt_run_state == run_fwd;
      cmd_ff.reverse <= nxt_run_state == run_rev;
    end
  end

  // up/down ramp in micro-hertz, one step per tick
  assign step = ((rate_ff == 16'h0) ? 32'h1 : {16'h0, rate_ff})
              * ((res_ff == drive_terms_pkg::RES_COARSE)
                 ? drive_terms_pkg::RES_COARSE_FACTOR : 32'h1); // RULE_08

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ramp_tick_ff <= 32'h0;
      freq_ff <= 32'h0;
    end
    else if (ce)
    begin
      ramp_tick_ff <= (ramp_tick_ff == 32'(RAMP_TICK_CYCLES - 1))
                    ? 32'h0 : ramp_tick_ff + 32'h1;
      if (ramp_tick_ff == 32'(RAMP_TICK_CYCLES - 1))
      begin
        if (frequency_up && !frequency_down) // RULE_07
          freq_ff <= (freq_ff > ~step) ? 32'hffffffff : freq_ff + step;
        else if (frequency_down && !frequency_up)
          freq_ff <= (freq_ff < step) ? 32'h0 : freq_ff - step;
      end
    end
  end

  // pulse rate: edges per window, in 0.01 kHz
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      window_ff <= 32'h0;
      edge_count_ff <= 16'h0;
      pulse_rate_ff <= 16'h0;
      pulse_prev_ff <= 1'b0;
    end
    else if (ce)
    begin
      pulse_prev_ff <= active[4];
      if (window_ff == 32'(PULSE_WINDOW_CYCLES - 1))
      begin
        window_ff <= 32'h0;
        pulse_rate_ff <= edge_count_ff; // RULE_14
        edge_count_ff <= 16'h0;
      end
      else
      begin
        window_ff <= window_ff + 32'h1;
        if (active[4] && !pulse_prev_ff && edge_count_ff != 16'hffff)
          edge_count_ff <= edge_count_ff + 16'h1;
      end
    end
  end

  // curve and current scaling
  assign sample[0] = current_ff[0] ? {1'b0, analog_input_one[15:1]} : analog_input_one; // RULE_12
  assign sample[1] = current_ff[1] ? {1'b0, analog_input_two[15:1]} : analog_input_two;

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_analog
      assign chosen[gi] = (dec_digit(curve_sel_ff, gi) == drive_terms_pkg::CURVE_TWO_CODE)
                        ? curve_ff[1] : curve_ff[0]; // RULE_15
    end
  endgenerate

  input_curve #(
    .IN_LIMIT(drive_terms_pkg::VOLT_LIMIT),
    .TICK_CYCLES(FILTER_TICK_CYCLES)
  ) u_curve_one (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .sample(sample[0]),
    .params(chosen[0]),
    .below_zero(dec_digit(below_ff, 0) == 4'h1),
    .setting_ff(setting_one)
  ); // RULE_09 RULE_11

  input_curve #(
    .IN_LIMIT(drive_terms_pkg::VOLT_LIMIT),
    .TICK_CYCLES(FILTER_TICK_CYCLES)
  ) u_curve_two (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .sample(sample[1]),
    .params(chosen[1]),
    .below_zero(dec_digit(below_ff, 1) == 4'h1),
    .setting_ff(setting_two)
  ); // RULE_09 RULE_11

  input_curve #(
    .IN_LIMIT(drive_terms_pkg::PULSE_LIMIT),
    .TICK_CYCLES(FILTER_TICK_CYCLES)
  ) u_curve_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .sample(pulse_rate_ff),
    .params(curve_ff[drive_terms_pkg::PULSE_SET]),
    .below_zero(1'b0),
    .setting_ff(pulse_setting)
  ); // RULE_14

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign forward_command = cmd_ff.forward;
  assign reverse_command = cmd_ff.reverse;
  assign updown_frequency = freq_ff;
endmodule

// ==== drive_terms_pkg.sv ====
// Purpose: constants and types for the terminal logic
// Assumes: 50 MHz pclk, APB register map
// Notes: units 0.01 V, 0.01 %, 0.01 kHz
package drive_terms_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int RAMP_TICK_US = 1000;
  localparam int RAMP_TICK_CYCLES = RAMP_TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int FILTER_TICK_MS = 10;
  localparam int FILTER_TICK_CYCLES = FILTER_TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DELAY_TICK_MS = 100;
  localparam int DELAY_TICK_CYCLES = DELAY_TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PULSE_WINDOW_MS = 100;
  localparam int PULSE_WINDOW_CYCLES = PULSE_WINDOW_MS * 1000000 / CLK_PERIOD_NS;
  // register offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] UPDOWN_RATE_OFFSET = 8'h04;
  localparam logic [7:0] CURVE_SELECT_OFFSET = 8'h08;
  localparam logic [7:0] BELOW_MIN_OFFSET = 8'h0c;
  localparam logic [7:0] DELAY_ONE_OFFSET = 8'h10;
  localparam logic [7:0] DELAY_TWO_OFFSET = 8'h14;
  localparam logic [7:0] POLARITY_OFFSET = 8'h18;
  localparam logic [7:0] STATUS_OFFSET = 8'h1c;
  localparam logic [7:0] UPDOWN_FREQ_OFFSET = 8'h20;
  localparam logic [7:0] CURVE_BASE_OFFSET = 8'h40;
  localparam logic [7:0] CURVE_LAST_OFFSET = 8'h9f;
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RES_LSB = 2;
  localparam int CTRL_CURRENT_ONE_BIT = 4;
  localparam int CTRL_CURRENT_TWO_BIT = 5;
  // reset values
  localparam logic [1:0] MODE_RESET = 2'h1;
  localparam logic [1:0] RES_RESET = 2'h2;
  localparam logic [15:0] UPDOWN_RATE_RESET = 16'h03e8;
  localparam logic [16:0] CURVE_SELECT_RESET = 17'h00141;
  localparam logic [16:0] BELOW_MIN_RESET = 17'h00000;
  localparam logic [16:0] POLARITY_RESET = 17'h00000;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  // codes and limits
  localparam logic [1:0] MODE_THREE_ONE = 2'h2;
  localparam logic [1:0] MODE_THREE_TWO = 2'h3;
  localparam logic [1:0] RES_COARSE = 2'h1;
  localparam logic [31:0] RES_COARSE_FACTOR = 32'h0000000a;
  localparam logic [15:0] VOLT_LIMIT = 16'h03e8;
  localparam logic [15:0] PULSE_LIMIT = 16'h1388;
  localparam logic [15:0] SET_LIMIT = 16'h2710;
  localparam logic [15:0] DELAY_LIMIT = 16'h8ca0;
  localparam logic [15:0] FILTER_LIMIT = 16'h03e8;
  localparam logic [3:0] CURVE_TWO_CODE = 4'h2;
  localparam int CURVE_SETS = 3;
  localparam int PULSE_SET = 2;

  typedef struct packed {
    logic [15:0] min_in;
    logic signed [15:0] min_set;
    logic [15:0] max_in;
    logic signed [15:0] max_set;
    logic [15:0] filter;
  } curve_param_type;

  typedef struct packed {
    logic run;
    logic forward;
    logic reverse;
  } run_cmd_type;

  localparam curve_param_type ANALOG_CURVE_RESET =
    '{16'h0000, 16'h0000, 16'h03e8, 16'h2710, 16'h000a};
  localparam curve_param_type PULSE_CURVE_RESET =
    '{16'h0000, 16'h0000, 16'h1388, 16'h2710, 16'h000a};
endpackage

// ==== input_curve.sv ====
// Purpose: filters one input and maps it onto a setting
// Assumes: value and limits in one unit
// Notes: first-order filter
`timescale 1ns/1ns
module input_curve #(
  parameter logic [15:0] IN_LIMIT = drive_terms_pkg::VOLT_LIMIT,
  parameter int TICK_CYCLES = drive_terms_pkg::FILTER_TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // sample and curve
  input wire logic [15:0] sample,
  input drive_terms_pkg::curve_param_type params,
  input wire logic below_zero,
  output logic signed [15:0] setting_ff
);
  logic [31:0] tick_ff;
  logic [23:0] acc_ff;
  logic [15:0] x;
  logic [15:0] y;
  logic signed [24:0] diff;
  logic signed [33:0] span_out;
  logic signed [33:0] nxt_setting;

  assign x = (sample > IN_LIMIT) ? IN_LIMIT : sample; // RULE_09
  assign diff = $signed({1'b0, x, 8'h00}) - $signed({1'b0, acc_ff});

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_ff <= 32'h0;
    else if (ce)
      tick_ff <= (tick_ff == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_ff + 32'h1;
  end

  // zero time constant copies the sample
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_ff <= 24'h0;
    else if (ce && tick_ff == 32'(TICK_CYCLES - 1))
    begin
      if (params.filter == 16'h0)
        acc_ff <= {x, 8'h00};
      else
        acc_ff <= 24'($signed({1'b0, acc_ff}) + diff / $signed({9'h0, params.filter})); // RULE_13
    end
  end

  always_comb
  begin
    y = acc_ff[23:8];
    if (y > params.max_in)
      y = params.max_in; // RULE_10
    span_out = 34'sh0;
    if (params.max_in > params.min_in)
      span_out = 34'(($signed({18'h0, y - params.min_in})
                 * ($signed({{18{params.max_set[15]}}, params.max_set})
                 - $signed({{18{params.min_set[15]}}, params.min_set})))
                 / $signed({18'h0, params.max_in - params.min_in}));
    if (y < params.min_in)
      nxt_setting = below_zero ? 34'sh0 : 34'(params.min_set); // RULE_11
    else
      nxt_setting = 34'(params.min_set) + span_out;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      setting_ff <= 16'sh0;
    else if (ce)
      setting_ff <= nxt_setting[15:0];
  end
endmodule

// ==== tb_drive_input_terminal_logic.sv ====
// Purpose: self-checking bench
// Assumes: short tick parameters, ce held high
// Notes: fixed random seed
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb_drive_input_terminal_logic;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err, pulse_on;
  logic frequency_up, frequency_down, forward_command, reverse_command;
  logic digital_input_one, digital_input_two, digital_input_three, digital_input_four;
  logic digital_input_five, enable_button, forward_or_start_button, reverse_button;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, updown_frequency, rd, f0;
  logic [15:0] analog_input_one, analog_input_two;
  logic signed [15:0] setting_one, setting_two, pulse_setting;
  logic [7:0] offs[5] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h30};
  logic [31:0] vals[5] = '{32'h9, 32'h3e8, 32'h141, 32'h0, 32'h0};
  int miscompares, cmp_count, seed, i, n, x;
  drive_input_terminal_logic #(.RAMP_TICK_CYCLES(10), .FILTER_TICK_CYCLES(4),
    .DELAY_TICK_CYCLES(10), .PULSE_WINDOW_CYCLES(100)) dut_u (.*);
  terminal_sources src_u (.*);
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    if (pready !== 1'b1)
    begin
      miscompares++;
      end_of_test();
    end
    {err, rd} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  task automatic press(input logic e, f, r, input logic [1:0] ex);
    @(posedge pclk);
    {enable_button, forward_or_start_button, reverse_button} <= {e, f, r};
    repeat (5) @(negedge pclk);
    `CHK({forward_command, reverse_command}, ex)
  endtask
  task automatic ana(input logic [15:0] v, input logic [15:0] e);
    @(posedge pclk);
    {analog_input_one, analog_input_two} <= {v, v};
    repeat (12) @(negedge pclk);
    `CHK(setting_one, e)
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pulse_on, digital_input_four} = '0;
    {frequency_up, frequency_down, enable_button, forward_or_start_button} = '0;
    {reverse_button, analog_input_one, analog_input_two, miscompares, cmp_count} = '0;
    ce = 1'b1;
    seed = 32'hb08f;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
      apb(1'b0, offs[i], 32'h0);
      `CHK({err, rd}, {i == 4, vals[i]})
    end
    apb(1'b1, 8'h00, 32'ha);
    press(1'b1, 1'b1, 1'b0, 2'b10);
    press(1'b1, 1'b0, 1'b1, 2'b01);
    press(1'b0, 1'b0, 1'b0, 2'b00);
    apb(1'b1, 8'h00, 32'hb);
    press(1'b1, 1'b1, 1'b0, 2'b10);
    press(1'b1, 1'b0, 1'b1, 2'b01);
    press(1'b0, 1'b0, 1'b1, 2'b00);
    apb(1'b1, 8'h18, 32'h64);
    apb(1'b1, 8'h00, 32'ha);
    press(1'b0, 1'b1, 1'b0, 2'b10);
    press(1'b1, 1'b0, 1'b0, 2'b00);
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h10, 32'h2);
    press(1'b1, 1'b1, 1'b0, 2'b00);
    repeat (30) @(negedge pclk);
    `CHK(forward_command, 1'b1)
    press(1'b0, 1'b0, 1'b0, 2'b00);
    for (i = 0; i < 2; i++)
    begin
      x = 1 + $unsigned($random(seed)) % 200;
      apb(1'b1, 8'h04, 32'(x));
      apb(1'b1, 8'h00, i ? 32'h6 : 32'ha);
      frequency_up <= 1'b1;
      @(negedge pclk);
      f0 = updown_frequency;
      for (n = 0; n < 40 && updown_frequency === f0; n++) @(negedge pclk);
      f0 = updown_frequency;
      repeat (100) @(negedge pclk);
      `CHK(updown_frequency - f0, 32'(x * (i ? 100 : 10)))
    end
    @(posedge pclk);
    {frequency_up, frequency_down} <= 2'b01;
    repeat (20000) @(negedge pclk);
    `CHK(updown_frequency, 32'h0)
    apb(1'b1, 8'h50, 32'h0);
    apb(1'b1, 8'h70, 32'h0);
    for (i = 0; i < 6; i++)
    begin
      x = $unsigned($random(seed)) % 1001;
      ana(16'(x), 16'(x * 10));
      `CHK(setting_two, 16'(x * 10))
    end
    ana(16'h05dc, 16'h2710);
    apb(1'b1, 8'h40, 32'hc8);
    apb(1'b1, 8'h44, 32'hffffec78);
    ana(16'h0064, 16'hec78);
    apb(1'b1, 8'h0c, 32'h1);
    ana(16'h0064, 16'h0000);
    apb(1'b1, 8'h00, 32'h19);
    ana(16'h04b0, 16'h09c4);
    apb(1'b1, 8'h00, 32'h9);
    apb(1'b1, 8'h08, 32'h16);
    ana(16'h0064, 16'h03e8);
    apb(1'b1, 8'h90, 32'h0);
    pulse_on <= 1'b1;
    repeat (400) @(negedge pclk);
    `CHK(pulse_setting > 0 && pulse_setting <= 16'sh28, 1'b1)
    end_of_test();
  end
endmodule

// ==== term_asserts.sv ====
// Purpose: port checks
// Assumes: mode and enable sense shadowed from apb writes
// Notes: ports grouped per line
`timescale 1ns/1ns
module term_asserts (
  // clock, reset, apb and ramp frequency
  input wire logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata, updown_frequency,
  // terminals and results
  input wire logic digital_input_three, frequency_up, forward_command, reverse_command,
  input wire logic signed [15:0] setting_one
);
  logic [1:0] mode_ff;
  logic inv_ff;
  logic en;
  assign en = digital_input_three ^ inv_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ff <= drive_terms_pkg::MODE_RESET;
      inv_ff <= 1'b0;
    end
    else if (psel && penable && pwrite && pready)
    begin
      if (paddr == drive_terms_pkg::CTRL_OFFSET) mode_ff <= pwdata[1:0];
      if (paddr == drive_terms_pkg::POLARITY_OFFSET) inv_ff <= pwdata / 100 % 10 != 0;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_READY_AFTER_SETUP: assert property (psel && !penable && ce |=> pready)
    else $error("setup not answered");
  AST_ERROR_ZERO_DATA: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response");
  AST_ONE_DIRECTION: assert property (!(forward_command && reverse_command))
    else $error("both directions");
  AST_START_ENABLED: assert property ($rose(forward_command) |-> $past(en))
    else $error("start without enable");
  AST_STOP_ON_DISABLE: assert property (mode_ff[1] && !en |=> !forward_command && !reverse_command)
    else $error("no stop");
  AST_TWO_WIRE_IDLE: assert property (!mode_ff[1] |=> !forward_command && !reverse_command)
    else $error("two-wire command");
  AST_RAMP_NO_RISE: assert property (!frequency_up |=> updown_frequency <= $past(updown_frequency))
    else $error("rose without up");
  AST_SETTING_LIMIT: assert property (setting_one <= 16'sh2710 && setting_one >= -16'sh2710)
    else $error("setting range");
  cover property (forward_command ##1 reverse_command);
  cover property (pslverr);
  cover property (frequency_up && $changed(updown_frequency));
endmodule
bind drive_input_terminal_logic term_asserts chk_u (.*);

// ==== terminal_sources.sv ====
// Purpose: switches and pulse source
// Assumes: closed reads high
// Notes: pulses ten cycles apart
`timescale 1ns/1ns
module terminal_sources (
  input wire logic pclk, enable_button, forward_or_start_button, reverse_button, pulse_on,
  output logic digital_input_one, digital_input_two, digital_input_three, digital_input_five
);
  logic [3:0] cnt_ff = 4'h0;
  assign digital_input_one = forward_or_start_button;
  assign digital_input_two = reverse_button;
  assign digital_input_three = enable_button;
  assign digital_input_five = pulse_on && cnt_ff < 4'h5;
  always_ff @(posedge pclk)
    cnt_ff <= cnt_ff == 4'h9 ? 4'h0 : cnt_ff + 4'h1;
endmodule
